/* File: core/pvi_pkg.sv */
// Package: constants and types of the prioritized vector interrupt controller
package pvi_pkg;

	// ******************************
	// Sizes
	// ******************************
	localparam int unsigned NUM_CHAN  = 128;
	localparam int unsigned LVL_W     = 3;
	localparam int unsigned ADDR_W    = 24;
	localparam int unsigned CHAN_W    = 7;

	// ******************************
	// Vector offsets (entry index = offset / 4)
	// ******************************
	localparam logic [23:0] RESET_VECTOR = 24'hfffffc;
	localparam logic [8:0]  OFF_PAGE1    = 9'h1f8;
	localparam logic [8:0]  OFF_PAGE2    = 9'h1f4;
	localparam logic [8:0]  OFF_SWINT    = 9'h1f0;
	localparam logic [8:0]  OFF_SYSCALL  = 9'h1ec;
	localparam logic [8:0]  OFF_MACHINE  = 9'h1e8;
	localparam logic [8:0]  OFF_SPURIOUS = 9'h1dc;
	localparam logic [8:0]  OFF_XMASK    = 9'h1d8;
	localparam logic [8:0]  OFF_EXTIRQ   = 9'h1d4;
	localparam logic [6:0]  CHAN_FIRST   = 7'h04;
	localparam logic [6:0]  CHAN_LAST    = 7'h75;
	localparam logic [6:0]  CHAN_SPUR    = 7'h77;

	// ******************************
	// Levels and reset values
	// ******************************
	localparam logic [2:0]  LVL_RESET    = 3'h1;
	localparam logic [2:0]  LVL_OFF      = 3'h0;
	localparam logic [7:0]  SPUR_CFG_RD  = 8'h07;
	localparam logic [14:0] VBASE_RESET  = 15'h7fff;

	// ******************************
	// APB register map (byte addresses)
	// ******************************
	localparam logic [7:0] REG_VECTOR_BASE = 8'h00;
	localparam logic [7:0] REG_BLOCK_SEL   = 8'h04;
	localparam logic [7:0] REG_WINDOW0     = 8'h20;
	localparam logic [7:0] REG_STATUS      = 8'h40;
	localparam int unsigned VBASE_LSB      = 9;
	localparam int unsigned BLK_LSB        = 3;
	localparam int unsigned STAT_LVL_LSB   = 24;

	typedef enum logic [2:0] {
		SRC_NONE     = 3'b000,
		SRC_RESET    = 3'b001,
		SRC_SOFTWARE = 3'b010,
		SRC_MACHINE  = 3'b011,
		SRC_XMASK    = 3'b100,
		SRC_MASKABLE = 3'b101,
		SRC_SPURIOUS = 3'b110
	} pvi_src_t;

	// Answer to the core for one vector fetch
	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic        loadLevel;
		logic [2:0]  level;
	} pvi_vec_t;

	// Non-maskable request set from the core and system
	typedef struct packed {
		logic resetReq;
		logic pageOneTrap;
		logic pageTwoTrap;
		logic softwareInterruptCall;
		logic systemCallRequest;
		logic machineException;
		logic accessViolation;
		logic xMaskableRequest;
	} pvi_nmi_t;

endpackage

/* File: core/pvi_ctrl.sv */
// Module: prioritized vector interrupt controller with APB configuration
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module pvi_ctrl
	import pvi_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [NUM_CHAN-1:0] maskableRequest,
	input  wire logic [NUM_CHAN-1:0] localEnable,
	input  wire pvi_nmi_t            nmiRequest,
	input  wire logic                interruptMaskBit,
	input  wire logic                xMaskBit,
	input  wire logic [2:0]          currentProcessingLevel,
	input  wire logic                vectorRequest,
	output pvi_vec_t                 vectorAnswer
);

	// ******************************
	// Helpers
	// ******************************
	// True for channels that hold a writable level field
	function automatic logic isConfigurable(input logic [6:0] ch);
		isConfigurable = (ch >= CHAN_FIRST) && (ch <= CHAN_LAST);
	endfunction

	function automatic logic [23:0] vecOf(input logic [14:0] base, input logic [8:0] off);
		vecOf = {base, 9'h000} + {15'h0000, off};
	endfunction

	// ******************************
	// Registers
	// ******************************
	logic [2:0]  cfgLevel_reg [NUM_CHAN];
	logic [14:0] vectorBase_reg;
	logic [3:0]  blockSelect_reg;
	pvi_vec_t    answer_reg;
	pvi_vec_t    answer_next;
	pvi_src_t    source_next;

	// ******************************
	// APB decode
	// ******************************
	wire         apbAccess  = psel && penable;
	wire         apbWrite   = apbAccess && pwrite;
	wire         hitBase    = (paddr == REG_VECTOR_BASE);
	wire         hitBlock   = (paddr == REG_BLOCK_SEL);
	wire         hitStatus  = (paddr == REG_STATUS);
	wire         hitWindow  = (paddr[7:5] == REG_WINDOW0[7:5]) && (paddr[1:0] == 2'b00);
	wire         hitAny     = hitBase || hitBlock || hitStatus || hitWindow;
	wire [6:0]   windowChan = {blockSelect_reg, paddr[4:2]};
	wire         cfgWrite   = apbWrite && hitWindow && isConfigurable(windowChan);

	assign pready  = 1'b1;
	assign pslverr = apbAccess && !hitAny;

	logic [7:0] windowRead;
	always_comb begin
		if (windowChan == CHAN_SPUR) begin
			windowRead = SPUR_CFG_RD;
		end else if (isConfigurable(windowChan)) begin
			windowRead = {5'h00, cfgLevel_reg[windowChan]};
		end else begin
			windowRead = 8'h00;
		end
	end

	logic [31:0] readMux;
	always_comb begin
		readMux = 32'h0000_0000;
		if (hitBase) begin
			readMux = {8'h00, vectorBase_reg, 9'h000};
		end else if (hitBlock) begin
			readMux = {25'h0, blockSelect_reg, 3'h0};
		end else if (hitWindow) begin
			readMux = {24'h0, windowRead};
		end else if (hitStatus) begin
			readMux = {5'h00, answer_reg.level, answer_reg.addr};
		end
	end
	assign prdata = (psel && !pwrite) ? readMux : 32'h0000_0000;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vectorBase_reg  <= VBASE_RESET;
			blockSelect_reg <= 4'h0;
		end else if (apbWrite && hitBase) begin
			vectorBase_reg  <= pwdata[23:VBASE_LSB];
		end else if (apbWrite && hitBlock) begin
			blockSelect_reg <= pwdata[BLK_LSB+3:BLK_LSB];
		end
	end

	// ******************************
	// Level storage
	// ******************************
	// Spurious and non-configurable slots never take writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				cfgLevel_reg[i] <= LVL_RESET;
			end
		end else if (cfgWrite) begin
			cfgLevel_reg[windowChan] <= pwdata[2:0];
		end
	end

	// ******************************
	// Priority decoder
	// ******************************
	wire softTrap = nmiRequest.pageOneTrap || nmiRequest.pageTwoTrap ||
	                nmiRequest.softwareInterruptCall || nmiRequest.systemCallRequest;
	wire machineLike = nmiRequest.machineException || nmiRequest.accessViolation;
	wire xPending    = nmiRequest.xMaskableRequest && !xMaskBit;
	wire holdOff     = softTrap || machineLike || xPending;
	wire maskOpen    = !interruptMaskBit && !holdOff;

	logic [NUM_CHAN-1:0] eligible;
	logic [6:0]          winChan;
	logic [2:0]          winLevel;
	logic                winValid;
	always_comb begin
		winChan  = 7'h00;
		winLevel = LVL_OFF;
		winValid = 1'b0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			eligible[i] = isConfigurable(7'(i)) && maskableRequest[i] && localEnable[i] &&
			              (cfgLevel_reg[i] != LVL_OFF) &&
			              (cfgLevel_reg[i] > currentProcessingLevel);
			// Ascending scan with >= lets the higher address win ties
			if (eligible[i] && (cfgLevel_reg[i] >= winLevel)) begin
				winChan  = 7'(i);
				winLevel = cfgLevel_reg[i];
				winValid = 1'b1;
			end
		end
	end

	// Fixed order of the non-maskable sources ahead of any maskable one
	always_comb begin
		answer_next = '0;
		source_next = SRC_NONE;
		answer_next.valid = 1'b1;
		if (nmiRequest.resetReq) begin
			answer_next.addr = RESET_VECTOR;
			source_next      = SRC_RESET;
		end else if (nmiRequest.pageOneTrap) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_PAGE1);
			source_next      = SRC_SOFTWARE;
		end else if (nmiRequest.pageTwoTrap) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_PAGE2);
			source_next      = SRC_SOFTWARE;
		end else if (nmiRequest.softwareInterruptCall) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_SWINT);
			source_next      = SRC_SOFTWARE;
		end else if (nmiRequest.systemCallRequest) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_SYSCALL);
			source_next      = SRC_SOFTWARE;
		end else if (machineLike) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_MACHINE);
			source_next      = SRC_MACHINE;
		end else if (xPending) begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_XMASK);
			source_next      = SRC_XMASK;
		end else if (maskOpen && winValid) begin
			answer_next.addr      = vecOf(vectorBase_reg, {winChan, 2'b00});
			answer_next.loadLevel = 1'b1;
			answer_next.level     = winLevel;
			source_next           = SRC_MASKABLE;
		end else begin
			answer_next.addr = vecOf(vectorBase_reg, OFF_SPURIOUS);
			source_next      = SRC_SPURIOUS;
		end
	end

	// ******************************
	// Vector answer
	// ******************************
	// Late arrivals do not win: the choice is made at the request edge only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			answer_reg     <= '0;
		end else if (vectorRequest) begin
			answer_reg     <= answer_next;
		end else begin
			answer_reg.valid     <= 1'b0;
			answer_reg.loadLevel <= 1'b0;
		end
	end
	assign vectorAnswer = answer_reg;

	// ******************************
	// Assertions
	// ******************************
	a_answer_timing: assert property (@(posedge mclk) disable iff (!rst_n)
		vectorRequest |=> vectorAnswer.valid)
		else $error("answer missing one cycle after request");

	a_answer_only_req: assert property (@(posedge mclk) disable iff (!rst_n)
		!vectorRequest |=> !vectorAnswer.valid)
		else $error("answer without request");

	a_reset_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && nmiRequest.resetReq) |=>
		(vectorAnswer.addr == RESET_VECTOR) && !vectorAnswer.loadLevel)
		else $error("reset vector wrong");

	a_nmi_keeps_level: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (softTrap || machineLike || xPending)) |=> !vectorAnswer.loadLevel)
		else $error("non-maskable fetch changed level");

	a_mask_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && interruptMaskBit) |=> !vectorAnswer.loadLevel)
		else $error("masked request served");

	a_level_raises: assert property (@(posedge mclk) disable iff (!rst_n)
		vectorAnswer.loadLevel |->
		(vectorAnswer.level > $past(currentProcessingLevel)) && (vectorAnswer.level != 3'h0))
		else $error("loaded level not above current");

	a_spurious_default: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && !nmiRequest.resetReq && !holdOff && !(maskOpen && winValid)) |=>
		(vectorAnswer.addr[8:0] == OFF_SPURIOUS))
		else $error("spurious vector not returned");

	a_spur_cfg_read: assert property (@(posedge mclk) disable iff (!rst_n)
		(psel && !pwrite && hitWindow && (windowChan == CHAN_SPUR)) |-> (prdata == 32'h7))
		else $error("spurious config read wrong");

	a_cfg_write: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgWrite |=> (cfgLevel_reg[$past(windowChan)] == $past(pwdata[2:0])))
		else $error("window write lost");

	a_vector_index: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && source_next == SRC_MASKABLE) |=>
		(vectorAnswer.addr[8:2] >= CHAN_FIRST) && (vectorAnswer.addr[8:2] <= CHAN_LAST) &&
		(vectorAnswer.addr[1:0] == 2'b00))
		else $error("maskable vector outside device range");

	a_page1_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:6] == 2'b01)) |=>
		(vectorAnswer.addr[8:0] == OFF_PAGE1))
		else $error("page one trap vector wrong");

	a_page2_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:5] == 3'b001)) |=>
		(vectorAnswer.addr[8:0] == OFF_PAGE2))
		else $error("page two trap vector wrong");

	a_swint_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:4] == 4'h1)) |=>
		(vectorAnswer.addr[8:0] == OFF_SWINT))
		else $error("software interrupt vector wrong");

	a_syscall_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:3] == 5'h01)) |=>
		(vectorAnswer.addr[8:0] == OFF_SYSCALL))
		else $error("system call vector wrong");

	a_machine_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:3] == 5'h00) && machineLike) |=>
		(vectorAnswer.addr[8:0] == OFF_MACHINE))
		else $error("machine exception vector wrong");

	a_xmask_vector: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (nmiRequest[7:1] == 7'h00) && nmiRequest.xMaskableRequest &&
		!xMaskBit) |=> (vectorAnswer.addr[8:0] == OFF_XMASK) && !vectorAnswer.loadLevel)
		else $error("x request vector wrong");

	a_trap_hold_off: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (softTrap || machineLike)) |=>
		(vectorAnswer.addr[8:0] >= OFF_MACHINE))
		else $error("maskable served while trap pending");

	a_vector_base: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && !nmiRequest.resetReq) |=>
		(vectorAnswer.addr[23:9] == $past(vectorBase_reg)))
		else $error("vector not relative to base");

	a_loaded_level: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (source_next == SRC_MASKABLE)) |=> vectorAnswer.loadLevel &&
		(vectorAnswer.level == cfgLevel_reg[vectorAnswer.addr[8:2]]))
		else $error("loaded level not the winner level");

	a_win_enabled: assert property (@(posedge mclk) disable iff (!rst_n)
		(vectorRequest && (source_next == SRC_MASKABLE)) |->
		maskableRequest[winChan] && localEnable[winChan] && !interruptMaskBit)
		else $error("winner not requesting or not enabled");

	a_addr_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		!vectorRequest |=> $stable(vectorAnswer.addr) && $stable(vectorAnswer.level))
		else $error("vector changed without request");

	a_spur_cfg_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		(apbWrite && hitWindow && (windowChan == CHAN_SPUR)) |=>
		(cfgLevel_reg[CHAN_SPUR] == $past(cfgLevel_reg[CHAN_SPUR])))
		else $error("spurious config write taken");

	a_block_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(apbWrite && hitBlock) |=>
		(blockSelect_reg == $past(pwdata[BLK_LSB+3:BLK_LSB])))
		else $error("block select write lost");

	a_base_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(apbWrite && hitBase) |=>
		(vectorBase_reg == $past(pwdata[23:VBASE_LSB])))
		else $error("vector base write lost");

	a_window_read: assert property (@(posedge mclk) disable iff (!rst_n)
		(psel && !pwrite && hitWindow && isConfigurable(windowChan)) |->
		(prdata == {29'h0, cfgLevel_reg[windowChan]}))
		else $error("window read wrong");

	a_unused_read: assert property (@(posedge mclk) disable iff (!rst_n)
		(psel && !pwrite && hitWindow && !isConfigurable(windowChan) &&
		(windowChan != CHAN_SPUR)) |-> (prdata == 32'h0))
		else $error("unused channel read not zero");

endmodule

/* File: verification/pvi_core_model.sv */
// Core-side model: issues vector fetches and keeps the processing level stack
`timescale 1ns/1ps
module pvi_core_model
	import pvi_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       go,
	input  wire logic       ret,
	input  wire pvi_vec_t   vectorAnswer,
	output logic            vectorRequest,
	output logic [2:0]      currentProcessingLevel
);
	// ************
	// Level stack
	// ************
	logic [2:0] stack [0:7];
	int         sp;

	assign vectorRequest = go;

	// Entry stacks the old level, return restores it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			currentProcessingLevel <= 3'h0;
			sp <= 0;
		end else if (vectorAnswer.valid && vectorAnswer.loadLevel) begin
			stack[sp] <= currentProcessingLevel;
			sp <= sp + 1;
			currentProcessingLevel <= vectorAnswer.level;
		end else if (ret && sp > 0) begin
			currentProcessingLevel <= stack[sp-1];
			sp <= sp - 1;
		end
	end
endmodule

/* File: verification/pvi_ctrl_tb.sv */
// Testbench of the prioritized vector interrupt controller
`timescale 1ns/1ps
module pvi_ctrl_tb
	import pvi_pkg::*;
;
	logic           mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic [127:0]   mreq, lenable;
	pvi_nmi_t       nmi;
	logic           iMask, xMask, go, ret, vectorRequest, se;
	logic [2:0]     cpl;
	pvi_vec_t       vecAns;
	int             err_count, n_checks;
	logic [23:0]    base;

	pvi_ctrl pvi_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .maskableRequest(mreq), .localEnable(lenable), .nmiRequest(nmi),
		.interruptMaskBit(iMask), .xMaskBit(xMask), .currentProcessingLevel(cpl),
		.vectorRequest(vectorRequest), .vectorAnswer(vecAns));
	pvi_core_model pvi_core_model_inst (.mclk(mclk), .rst_n(rst_n), .go(go), .ret(ret),
		.vectorAnswer(vecAns), .vectorRequest(vectorRequest), .currentProcessingLevel(cpl));

	// ************
	// Shared tasks
	// ************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only pready or the watchdog ends a wait for ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	// Expected vector from the core's point of view
	task automatic fetch(input logic [23:0] ea, input logic el, input logic [2:0] lv);
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		// Answer stands for the cycle after the request edge
		@(posedge mclk);
		chk(vecAns.valid, 1'b1);
		chk(vecAns.addr, ea);
		chk(vecAns.loadLevel, el);
		if (el) chk(vecAns.level, lv);
	endtask

	task automatic pop();
		@(posedge mclk); ret <= 1'b1;
		@(posedge mclk); ret <= 1'b0;
	endtask

	// ************
	// Scenarios
	// ************
	task automatic t_reset();
		apb(0, REG_VECTOR_BASE, 0); chk(rd[23:0], 24'hfffe00);
		apb(0, 8'h30, 0); chk(rd[2:0], 3'h1);
		apb(0, 8'h20, 0); chk(rd, 32'h0);
	endtask

	task automatic t_arbit();
		mreq[10] <= 1'b1; mreq[20] <= 1'b1;
		fetch(base + 24'h50, 1, 3'h1); pop();
		apb(1, REG_BLOCK_SEL, 32'h8); apb(1, 8'h28, 32'h3);
		apb(0, 8'h28, 0); chk(rd[2:0], 3'h3);
		fetch(base + 24'h28, 1, 3'h3);
		fetch(base + 24'h1dc, 0, 3'h0); pop();
		apb(1, 8'h28, 32'h0);
		fetch(base + 24'h50, 1, 3'h1); pop();
		iMask <= 1'b1;
		fetch(base + 24'h1dc, 0, 3'h0);
		iMask <= 1'b0; lenable[20] <= 1'b0;
		fetch(base + 24'h1dc, 0, 3'h0);
		lenable[20] <= 1'b1;
	endtask

	task automatic t_nmi();
		logic [8:0] off [0:7];
		off = '{9'h0, 9'h1f8, 9'h1f4, 9'h1f0, 9'h1ec, 9'h1e8, 9'h1e8, 9'h1d8};
		for (int k = 0; k < 8; k++) begin
			nmi <= pvi_nmi_t'(8'h80 >> k);
			fetch(k == 0 ? 24'hfffffc : base + 24'(off[k]), 0, 3'h0);
		end
		nmi <= pvi_nmi_t'(8'h06);
		fetch(base + 24'h1e8, 0, 3'h0);
		chk(cpl, 3'h0);
		// Masked x request must not hold off maskables
		nmi <= pvi_nmi_t'(8'h01); xMask <= 1'b1;
		fetch(base + 24'h50, 1, 3'h1); pop();
		nmi <= '0; xMask <= 1'b0;
	endtask

	task automatic t_regs();
		apb(1, REG_BLOCK_SEL, 32'h70); apb(1, 8'h3c, 32'h0);
		apb(0, 8'h3c, 0); chk(rd[7:0], 8'h07);
		apb(0, 8'h80, 0); chk(se, 1'b1);
		apb(1, REG_VECTOR_BASE, 32'h123400); base = 24'h123400;
		fetch(base + 24'h50, 1, 3'h1); pop();
		apb(0, REG_STATUS, 0); chk(rd, {5'h00, 3'h1, base + 24'h50});
		mreq <= '0;
		fetch(base + 24'h1dc, 0, 3'h0);
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#200000;
		err_count++;
		test_done();
	end

	initial begin
		rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		mreq = '0; lenable = '1; nmi = '0; iMask = 0; xMask = 0; go = 0; ret = 0;
		err_count = 0; n_checks = 0; base = 24'hfffe00;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_arbit();
		t_nmi();
		t_regs();
		test_done();
	end
endmodule
